/* File: design/sdrt_ctrl.sv */
// Memory controller end: request buffer, per-bank timing and data movement.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sdrt_ctrl
    import sdrt_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Request stream from the user.
    input wire logic i_req_valid,
    input wire sdrt_op_e i_req_op,
    input wire logic [BANK_W-1:0] i_req_bank,
    input wire sdrt_addr_t i_req_addr,
    input wire logic i_req_long,
    input wire logic [DQ_W-1:0] i_req_wdata,
    output logic o_req_ready,
    // Read data and status back to the user.
    output logic [DQ_W-1:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_idle,
    // Link toward the device.
    sdrt_link_if.ctrl link
);
    typedef enum logic [1:0] {
        W_IDLE = 2'b00,
        W_WAIT = 2'b01,
        W_SEND = 2'b10
    } sdrt_wstate_e;

    sdrt_req_s fifo_q [0:1];
    logic wp_q;
    logic rp_q;
    logic [1:0] cnt_q;
    sdrt_addr_t mr0_q;
    sdrt_addr_t mr1_q;
    sdrt_cnt_t pre_wait_q [0:NBANK-1];
    sdrt_cnt_t act_wait_q [0:NBANK-1];
    sdrt_cnt_t col_wait_q;
    logic cmd_valid_q;
    sdrt_op_e cmd_op_q;
    logic [BANK_W-1:0] cmd_bank_q;
    sdrt_addr_t cmd_addr_q;
    sdrt_wstate_e ws_q;
    sdrt_cnt_t wr_cnt_q;
    logic wr_chop_q;
    logic [DQ_W-1:0] wr_base_q;
    logic [3:0] wbeat_q;
    logic [DQ_W-1:0] wdq_q;
    logic wdq_valid_q;
    logic [DQ_W-1:0] rd_data_q;
    logic rd_valid_q;

    // Counter step: count down, or take a later limit when one is loaded.
    function automatic sdrt_cnt_t next_wait(input sdrt_cnt_t cur, input logic load,
                                            input sdrt_cnt_t gap);
        sdrt_cnt_t dec;
        dec = (cur != '0) ? cur - ONE_CK : '0;
        return (load && gap > dec) ? gap : dec;
    endfunction

    // Two-entry request buffer; its ready is the user's back-pressure.
    wire logic push = i_req_valid && o_req_ready;
    wire sdrt_req_s hd = fifo_q[rp_q];
    wire logic hd_valid = cnt_q != 2'h0;
    assign o_req_ready = cnt_q != FIFO_DEPTH;

    // Head command decode.
    wire logic hd_act = hd.op == OP_ACT;
    wire logic hd_rd = hd.op == OP_RD;
    wire logic hd_wr = hd.op == OP_WR;
    wire logic hd_pre = hd.op == OP_PRE;
    wire logic hd_mrs = hd.op == OP_MRS;
    wire logic hd_ap = hd_rd && hd.addr[ADDR_AP_BIT];

    // Issue only when the bank or column spacing for this command has run out.
    wire logic act_ok = act_wait_q[hd.bank] == '0;
    wire logic pre_ok = pre_wait_q[hd.bank] == '0;
    wire logic col_ok = col_wait_q == '0;
    wire logic legal = hd_act ? act_ok : (hd_pre ? pre_ok : col_ok);
    wire logic issue = hd_valid && legal;

    // Latencies under the current mode settings.
    wire sdrt_cnt_t rl = rd_lat(mr0_q, mr1_q);
    wire sdrt_cnt_t wl = wr_lat(mr0_q, mr1_q);
    wire sdrt_cnt_t al_rtp = al_cycles(mr0_q) + rtp_cycles(mr0_q);
    wire sdrt_cnt_t slot = sdrt_cnt_t'(BEATS_FULL) + PREAMBLE_GAP - ONE_CK;

    // Spacing limits loaded for the head command.
    wire sdrt_cnt_t pre_gap = hd_act ? ACTIVATE_TO_PRECHARGE_MIN_CK - ONE_CK : al_rtp - ONE_CK;
    wire logic pre_load = hd_act || hd_rd;
    wire sdrt_cnt_t act_gap = hd_act ? TRC_CK - ONE_CK :
        (hd_pre ? TRP_CK - ONE_CK : al_rtp + TRP_CK - ONE_CK);
    wire logic act_load = hd_act || hd_pre || hd_ap;
    wire sdrt_cnt_t col_gap = hd_rd ? rl + slot : (hd_wr ? wl + slot : MRS_GAP);
    wire logic col_load = hd_rd || hd_wr || hd_mrs;

    // Burst-length selection line; driven only in per-command mode.
    wire logic per_command_selection = mr0_q[MR0_BL_LSB +: 2] == BL_OTF;
    wire logic bc_line = per_command_selection && hd.long_burst;
    wire sdrt_addr_t col_addr = {bc_line, hd.addr[ADDR_BC_BIT-1:0]};

    // Two-cycle write preamble forces the raised write cas setting.
    wire sdrt_addr_t mr1_prog = {hd.addr[ADDR_W-1:MR1_CWL_UP_BIT+1],
        hd.addr[MR1_CWL_UP_BIT] | hd.addr[MR1_WPRE2_BIT],
        hd.addr[MR1_CWL_UP_BIT-1:0]};
    wire logic mr1_sel = hd_mrs && hd.bank == MR_SEL_ONE;
    wire sdrt_addr_t cmd_addr_d = mr1_sel ? mr1_prog : ((hd_rd || hd_wr) ? col_addr : hd.addr);

    // Write burst engine state.
    wire logic [3:0] w_len = wr_chop_q ? BEATS_CHOP : BEATS_FULL;
    wire logic w_start = ws_q == W_WAIT && wr_cnt_q == ONE_CK;
    wire logic w_emit = w_start || (ws_q == W_SEND && wbeat_q < w_len);

    // Request buffer pointers and fill count.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) wp_q <= ~wp_q;
            if (issue) rp_q <= ~rp_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, issue};
        end
    end

    // Buffer entries hold data only.
    always_ff @(posedge i_clk) begin
        if (push) begin
            fifo_q[wp_q] <= '{op: i_req_op, bank: i_req_bank, addr: i_req_addr,
                              long_burst: i_req_long, wdata: i_req_wdata};
        end
    end

    // Copies of the device mode registers taken as they are programmed.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mr0_q <= MR_RST;
            mr1_q <= MR_RST;
        end else if (issue && hd_mrs) begin
            if (hd.bank == MR_SEL_ZERO) mr0_q <= hd.addr;
            if (mr1_sel) mr1_q <= mr1_prog;
        end
    end

    // Per-bank earliest precharge and activate counters.
    always_ff @(posedge i_clk) begin
        for (int b = 0; b < NBANK; b++) begin
            if (i_sys_rst) begin
                pre_wait_q[b] <= '0;
                act_wait_q[b] <= '0;
            end else begin
                pre_wait_q[b] <= next_wait(pre_wait_q[b],
                    issue && pre_load && hd.bank == BANK_W'(b), pre_gap);
                act_wait_q[b] <= next_wait(act_wait_q[b],
                    issue && act_load && hd.bank == BANK_W'(b), act_gap);
            end
        end
    end

    // Column spacing keeps one data burst on the lanes at a time.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            col_wait_q <= '0;
        end else begin
            col_wait_q <= next_wait(col_wait_q, issue && col_load, col_gap);
        end
    end

    // Registered command lanes.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cmd_valid_q <= 1'b0;
            cmd_op_q <= OP_MRS;
            cmd_bank_q <= '0;
            cmd_addr_q <= MR_RST;
        end else begin
            cmd_valid_q <= issue;
            cmd_op_q <= issue ? hd.op : OP_MRS;
            cmd_bank_q <= issue ? hd.bank : '0;
            cmd_addr_q <= issue ? cmd_addr_d : MR_RST;
        end
    end

    // Write burst engine: waits out the write latency, then drives beats.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ws_q <= W_IDLE;
            wr_cnt_q <= '0;
            wr_chop_q <= 1'b0;
            wr_base_q <= '0;
            wbeat_q <= 4'h0;
        end else begin
            unique case (ws_q)
                W_IDLE: begin
                    if (issue && hd_wr) begin
                        ws_q <= W_WAIT;
                        wr_cnt_q <= wl;
                        wr_chop_q <= is_chop(mr0_q, bc_line);
                        wr_base_q <= hd.wdata;
                        wbeat_q <= 4'h0;
                    end
                end
                W_WAIT: begin
                    wr_cnt_q <= wr_cnt_q - ONE_CK;
                    if (w_start) ws_q <= W_SEND;
                end
                W_SEND: begin
                    if (!w_emit) ws_q <= W_IDLE;
                end
                default: ws_q <= W_IDLE;
            endcase
            if (w_emit) wbeat_q <= wbeat_q + 4'h1;
        end
    end

    // Registered write lanes; beat n carries the base value plus n.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wdq_q <= '0;
            wdq_valid_q <= 1'b0;
        end else begin
            wdq_valid_q <= w_emit;
            wdq_q <= w_emit ? wr_base_q + DQ_W'(wbeat_q) : '0;
        end
    end

    // Read return; an inverted beat is turned back before the user sees it.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rd_data_q <= '0;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= link.rdq_valid;
            rd_data_q <= link.rdq_valid ? (link.rdq_inv ? ~link.rdq : link.rdq) : '0;
        end
    end

    assign link.cmd_valid = cmd_valid_q;
    assign link.cmd_op = cmd_op_q;
    assign link.cmd_bank = cmd_bank_q;
    assign link.cmd_addr = cmd_addr_q;
    assign link.wdq = wdq_q;
    assign link.wdq_valid = wdq_valid_q;
    assign o_rd_data = rd_data_q;
    assign o_rd_valid = rd_valid_q;
    assign o_idle = !hd_valid && col_ok && ws_q == W_IDLE;
endmodule
`default_nettype wire

/* File: design/sdrt_dev.sv */
// Memory device end: mode registers, read latency, bursts and auto precharge.
`timescale 1ns/1ps
`default_nettype none
module sdrt_dev
    import sdrt_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Link toward the controller.
    sdrt_link_if.dev link,
    // Visible device state.
    output logic [NBANK-1:0] o_bank_open,
    output sdrt_addr_t o_mode0,
    output sdrt_addr_t o_mode1
);
    sdrt_addr_t mr0_q;
    sdrt_addr_t mr1_q;
    logic [NBANK-1:0] open_q;
    logic [DQ_W-1:0] mem_q [0:(1<<MEM_W)-1];
    logic rd_pend_q;
    logic rd_burst_q;
    logic rd_chop_q;
    logic [BANK_W-1:0] rd_bank_q;
    sdrt_cnt_t rd_cnt_q;
    logic [3:0] rd_beat_q;
    logic wr_chop_q;
    logic [BANK_W-1:0] wr_bank_q;
    logic [3:0] wr_beat_q;
    logic ap_pend_q;
    logic [BANK_W-1:0] ap_bank_q;
    sdrt_cnt_t ap_cnt_q;
    logic [DQ_W-1:0] rdq_q;
    logic rdq_valid_q;
    logic rdq_inv_q;

    // Command decode from the link.
    wire logic is_mrs = link.cmd_valid && link.cmd_op == OP_MRS;
    wire logic is_act = link.cmd_valid && link.cmd_op == OP_ACT;
    wire logic is_rd = link.cmd_valid && link.cmd_op == OP_RD;
    wire logic is_wr = link.cmd_valid && link.cmd_op == OP_WR;
    wire logic is_pre = link.cmd_valid && link.cmd_op == OP_PRE;
    wire logic is_ap = is_rd && link.cmd_addr[ADDR_AP_BIT];
    wire logic cmd_chop = is_chop(mr0_q, link.cmd_addr[ADDR_BC_BIT]);
    wire sdrt_cnt_t rl = rd_lat(mr0_q, mr1_q);
    wire sdrt_cnt_t ap_delay = al_cycles(mr0_q) + rtp_cycles(mr0_q);

    // Read burst sequencing; a chopped burst leaves the back half idle.
    wire logic rd_start = rd_pend_q && rd_cnt_q == ONE_CK;
    wire logic [3:0] rd_len = rd_chop_q ? BEATS_CHOP : BEATS_FULL;
    wire logic [3:0] rd_idx = rd_start ? 4'h0 : rd_beat_q;
    wire logic rd_emit = rd_start || rd_burst_q;
    wire logic [DQ_W-1:0] rd_word = mem_q[{rd_bank_q, rd_idx[2:0]}];
    wire logic rd_flip = mr1_q[MR1_DBI_BIT] && dbi_flip(rd_word);

    // Write beats beyond the burst length are ignored.
    wire logic [3:0] wr_len = wr_chop_q ? BEATS_CHOP : BEATS_FULL;
    wire logic wr_take = link.wdq_valid && wr_beat_q < wr_len;
    wire logic ap_fire = ap_pend_q && ap_cnt_q == ONE_CK;

    // Mode registers and bank state.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mr0_q <= MR_RST;
            mr1_q <= MR_RST;
            open_q <= '0;
        end else begin
            if (is_mrs && link.cmd_bank == MR_SEL_ZERO) mr0_q <= link.cmd_addr;
            if (is_mrs && link.cmd_bank == MR_SEL_ONE) mr1_q <= link.cmd_addr;
            if (ap_fire) open_q[ap_bank_q] <= 1'b0;
            if (is_pre) open_q[link.cmd_bank] <= 1'b0;
            if (is_act) open_q[link.cmd_bank] <= 1'b1;
        end
    end

    // Internal precharge of an auto-precharge read.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ap_pend_q <= 1'b0;
            ap_cnt_q <= '0;
            ap_bank_q <= '0;
        end else if (is_ap) begin
            ap_pend_q <= 1'b1;
            ap_cnt_q <= ap_delay;
            ap_bank_q <= link.cmd_bank;
        end else if (ap_pend_q) begin
            ap_cnt_q <= ap_cnt_q - ONE_CK;
            ap_pend_q <= !ap_fire;
        end
    end

    // Read latency countdown and burst beat counter.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rd_pend_q <= 1'b0;
            rd_cnt_q <= '0;
            rd_chop_q <= 1'b0;
            rd_bank_q <= '0;
            rd_burst_q <= 1'b0;
            rd_beat_q <= 4'h0;
        end else begin
            if (is_rd) begin
                rd_pend_q <= 1'b1;
                rd_cnt_q <= rl - ONE_CK;
                rd_chop_q <= cmd_chop;
                rd_bank_q <= link.cmd_bank;
            end else if (rd_pend_q) begin
                rd_cnt_q <= rd_cnt_q - ONE_CK;
                rd_pend_q <= !rd_start;
            end
            if (rd_emit) begin
                rd_beat_q <= rd_idx + 4'h1;
                rd_burst_q <= rd_idx + 4'h1 < rd_len;
            end
        end
    end

    // Registered read lanes with the inversion flag beside each beat.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rdq_q <= '0;
            rdq_valid_q <= 1'b0;
            rdq_inv_q <= 1'b0;
        end else begin
            rdq_valid_q <= rd_emit;
            rdq_q <= rd_emit ? (rd_flip ? ~rd_word : rd_word) : '0;
            rdq_inv_q <= rd_emit && rd_flip;
        end
    end

    // Write capture into the bank storage.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wr_chop_q <= 1'b0;
            wr_bank_q <= '0;
            wr_beat_q <= BEATS_FULL;
        end else if (is_wr) begin
            wr_chop_q <= cmd_chop;
            wr_bank_q <= link.cmd_bank;
            wr_beat_q <= 4'h0;
        end else if (wr_take) begin
            wr_beat_q <= wr_beat_q + 4'h1;
        end
    end

    // Storage array; contents are data and need no reset.
    always_ff @(posedge i_clk) begin
        if (wr_take) mem_q[{wr_bank_q, wr_beat_q[2:0]}] <= link.wdq;
    end

    assign link.rdq = rdq_q;
    assign link.rdq_valid = rdq_valid_q;
    assign link.rdq_inv = rdq_inv_q;
    assign o_bank_open = open_q;
    assign o_mode0 = mr0_q;
    assign o_mode1 = mr1_q;
endmodule
`default_nettype wire

/* File: design/sdrt_link_if.sv */
// Command and data link between the memory controller and the memory device.
`timescale 1ns/1ps
`default_nettype none
interface sdrt_link_if;
    import sdrt_pkg::*;
    logic cmd_valid;
    sdrt_op_e cmd_op;
    logic [BANK_W-1:0] cmd_bank;
    sdrt_addr_t cmd_addr;
    logic [DQ_W-1:0] wdq;
    logic wdq_valid;
    logic [DQ_W-1:0] rdq;
    logic rdq_valid;
    logic rdq_inv;
    modport ctrl (
        output cmd_valid, cmd_op, cmd_bank, cmd_addr, wdq, wdq_valid,
        input rdq, rdq_valid, rdq_inv
    );
    modport dev (
        input cmd_valid, cmd_op, cmd_bank, cmd_addr, wdq, wdq_valid,
        output rdq, rdq_valid, rdq_inv
    );
endinterface
`default_nettype wire

/* File: design/sdrt_pkg.sv */
// Shared constants, types and latency helpers for the read-timing memory link.
package sdrt_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int NBANK = 4;
    localparam int BANK_W = 2;
    localparam int ADDR_W = 13;
    localparam int DQ_W = 8;
    localparam int CNT_W = 8;
    localparam int MEM_W = 5;

    typedef logic [ADDR_W-1:0] sdrt_addr_t;
    typedef logic [CNT_W-1:0] sdrt_cnt_t;
    typedef enum logic [2:0] {
        OP_MRS = 3'b000,
        OP_ACT = 3'b001,
        OP_RD = 3'b010,
        OP_WR = 3'b011,
        OP_PRE = 3'b100
    } sdrt_op_e;
    typedef struct packed {
        sdrt_op_e op;
        logic [BANK_W-1:0] bank;
        sdrt_addr_t addr;
        logic long_burst;
        logic [DQ_W-1:0] wdata;
    } sdrt_req_s;

    // Mode register selection, field positions and codes.
    localparam logic [BANK_W-1:0] MR_SEL_ZERO = 2'h0;
    localparam logic [BANK_W-1:0] MR_SEL_ONE = 2'h1;
    localparam int MR0_BL_LSB = 0;
    localparam int MR0_AL_LSB = 3;
    localparam int MR0_RTP_LSB = 9;
    localparam int MR1_DBI_BIT = 0;
    localparam int MR1_PAR_BIT = 1;
    localparam int MR1_WPRE2_BIT = 2;
    localparam int MR1_CWL_UP_BIT = 3;
    localparam int ADDR_AP_BIT = 10;
    localparam int ADDR_BC_BIT = 12;
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_CHOP4 = 2'h2;
    localparam logic [1:0] AL_CL_M1 = 2'h1;
    localparam logic [1:0] AL_CL_M2 = 2'h2;
    localparam sdrt_addr_t MR_RST = 13'h0000;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;

    // Latency and burst figures in clock cycles.
    localparam sdrt_cnt_t CL_CK = 8'h0b;
    localparam sdrt_cnt_t CWL_CK = 8'h09;
    localparam sdrt_cnt_t PL_CK = 8'h04;
    localparam sdrt_cnt_t DBI_ADD_CK = 8'h02;
    localparam sdrt_cnt_t RTP_BASE = 8'h05;
    localparam sdrt_cnt_t ONE_CK = 8'h01;
    localparam sdrt_cnt_t AL_M1 = 8'h01;
    localparam sdrt_cnt_t AL_M2 = 8'h02;
    localparam sdrt_cnt_t PREAMBLE_GAP = 8'h02;
    localparam sdrt_cnt_t MRS_GAP = 8'h04;
    localparam logic [3:0] BEATS_FULL = 4'h8;
    localparam logic [3:0] BEATS_CHOP = 4'h4;

    // Times in their own units and the derived cycle counts.
    localparam int RTP_MIN_NCK = 4;
    localparam int RTP_MIN_PS = 7500;
    localparam int ACTIVATE_TO_PRECHARGE_MIN_NS = 35;
    localparam int TRP_NS = 15;
    localparam int TRC_NS = 50;
    localparam int RTP_PS_CK = (RTP_MIN_PS + CLK_PERIOD_NS * 1000 - 1) / (CLK_PERIOD_NS * 1000);
    localparam sdrt_cnt_t RTP_MIN_CYC =
        sdrt_cnt_t'(RTP_MIN_NCK > RTP_PS_CK ? RTP_MIN_NCK : RTP_PS_CK);
    localparam sdrt_cnt_t ACTIVATE_TO_PRECHARGE_MIN_CK = sdrt_cnt_t'((ACTIVATE_TO_PRECHARGE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam sdrt_cnt_t TRP_CK = sdrt_cnt_t'((TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam sdrt_cnt_t TRC_CK = sdrt_cnt_t'((TRC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Additive latency from its mode code.
    function automatic sdrt_cnt_t al_cycles(input sdrt_addr_t mr0);
        logic [1:0] code;
        code = mr0[MR0_AL_LSB +: 2];
        if (code == AL_CL_M1) return CL_CK - AL_M1;
        if (code == AL_CL_M2) return CL_CK - AL_M2;
        return '0;
    endfunction

    // Internal read-to-precharge delay, never below its minimum.
    function automatic sdrt_cnt_t rtp_cycles(input sdrt_addr_t mr0);
        sdrt_cnt_t v;
        v = sdrt_cnt_t'(mr0[MR0_RTP_LSB +: 3]) + RTP_BASE;
        return (v > RTP_MIN_CYC) ? v : RTP_MIN_CYC;
    endfunction

    // Total read latency with all adders.
    function automatic sdrt_cnt_t rd_lat(input sdrt_addr_t mr0, input sdrt_addr_t mr1);
        return CL_CK + al_cycles(mr0) + (mr1[MR1_PAR_BIT] ? PL_CK : '0)
            + (mr1[MR1_DBI_BIT] ? DBI_ADD_CK : '0);
    endfunction

    // Total write latency with all adders.
    function automatic sdrt_cnt_t wr_lat(input sdrt_addr_t mr0, input sdrt_addr_t mr1);
        return CWL_CK + (mr1[MR1_CWL_UP_BIT] ? ONE_CK : '0) + al_cycles(mr0)
            + (mr1[MR1_PAR_BIT] ? PL_CK : '0);
    endfunction

    // True when a column command moves a four-beat chopped burst.
    function automatic logic is_chop(input sdrt_addr_t mr0, input logic bc_line);
        return mr0[MR0_BL_LSB +: 2] == BL_CHOP4 || (mr0[MR0_BL_LSB +: 2] == BL_OTF && !bc_line);
    endfunction

    // True when more than half the lanes of a word are zero.
    function automatic logic dbi_flip(input logic [DQ_W-1:0] d);
        logic [3:0] zeros;
        zeros = 4'h0;
        for (int i = 0; i < DQ_W; i++) zeros = zeros + {3'b000, ~d[i]};
        return zeros > 4'(DQ_W / 2);
    endfunction
endpackage

/* File: sim/sdrt_link_monitor.sv */
// Link checker: read latency, burst length and read-to-precharge spacing.
`timescale 1ns/1ps
`default_nettype none
module sdrt_link_monitor
    import sdrt_pkg::*;
(
    // Clock, reset and the link signals watched.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic cmd_valid,
    input wire sdrt_op_e cmd_op,
    input wire logic [BANK_W-1:0] cmd_bank,
    input wire sdrt_addr_t cmd_addr,
    input wire logic rdq_valid,
    input wire logic rdq_inv
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sdrt_addr_t m0_q;
    sdrt_addr_t m1_q;
    sdrt_cnt_t age_q;
    logic [BANK_W-1:0] rbank_q;
    // Command decodes.
    wire logic rd = cmd_valid && cmd_op == OP_RD;
    wire logic mrs = cmd_valid && cmd_op == OP_MRS;
    wire logic bc = cmd_addr[ADDR_BC_BIT];
    // Mode copies, so each latency check knows the active setting.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            m0_q <= MR_RST;
            m1_q <= MR_RST;
            age_q <= 8'hff;
            rbank_q <= 2'h0;
        end else begin
            if (mrs && cmd_bank == MR_SEL_ZERO) m0_q <= cmd_addr;
            if (mrs && cmd_bank == MR_SEL_ONE) m1_q <= cmd_addr;
            if (rd) begin
                age_q <= 8'h01;
                rbank_q <= cmd_bank;
            end else if (age_q != 8'hff) begin
                age_q <= age_q + 8'h01;
            end
        end
    end
    a_fixed_eight: assert property (rd && m0_q == 13'h0000 && m1_q == 13'h0000 |->
        ##11 rdq_valid [*8] ##1 !rdq_valid) else $error("fixed eight wrong");
    a_fixed_chop: assert property (rd && m0_q == 13'h0002 && m1_q == 13'h0000 |->
        ##11 rdq_valid [*4] ##1 !rdq_valid) else $error("fixed chop wrong");
    a_otf_eight: assert property (rd && m0_q == 13'h0001 && m1_q == 13'h0000 && bc |->
        ##11 rdq_valid [*8] ##1 !rdq_valid) else $error("select high wrong");
    a_otf_chop: assert property (rd && m0_q == 13'h0001 && m1_q == 13'h0000 && !bc |->
        ##11 rdq_valid [*4] ##1 !rdq_valid) else $error("select low wrong");
    a_inv_adder: assert property (rd && m0_q == 13'h0000 && m1_q == 13'h0001 |->
        ##12 !rdq_valid ##1 rdq_valid [*8]) else $error("inversion latency wrong");
    a_inv_flag: assert property (rdq_inv |-> rdq_valid && m1_q[MR1_DBI_BIT])
        else $error("stray inversion flag");
    a_parity_adder: assert property (rd && m0_q == 13'h0000 && m1_q == 13'h0002 |->
        ##14 !rdq_valid ##1 rdq_valid) else $error("parity latency wrong");
    a_additive_lat: assert property (rd && m0_q == 13'h0010 && m1_q == 13'h0000 |->
        ##19 !rdq_valid ##1 rdq_valid) else $error("additive latency wrong");
    a_read_to_pre: assert property (cmd_valid && cmd_op == OP_PRE && cmd_bank == rbank_q
        && m0_q == 13'h0200 |-> age_q >= 8'h06) else $error("precharge too soon");
endmodule
`default_nettype wire

/* File: sim/sdrt_read_turnaround_timing_test.sv */
// Testbench: controller and device joined over the link, driven from the user port.
`timescale 1ns/1ps
`default_nettype none
module sdrt_read_turnaround_timing_test
    import sdrt_pkg::*;
;
    logic i_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    sdrt_op_e req_op = OP_MRS;
    logic [1:0] req_bank = 2'h0;
    sdrt_addr_t req_addr = 13'h0000;
    logic req_long = 1'b0;
    logic [7:0] req_wdata = 8'h00;
    logic req_ready, rd_valid, idle;
    logic [7:0] rd_data;
    logic [3:0] bank_open;
    sdrt_addr_t mode0, mode1;
    int mismatches = 0;
    int comparisons = 0;
    // Free-running 100 MHz clock.
    always #5 i_clk = ~i_clk;
    sdrt_link_if link();
    sdrt_ctrl u_sdrt_ctrl (.i_clk(i_clk), .i_sys_rst(rst), .i_req_valid(req_valid),
        .i_req_op(req_op), .i_req_bank(req_bank), .i_req_addr(req_addr), .i_req_long(req_long),
        .i_req_wdata(req_wdata), .o_req_ready(req_ready), .o_rd_data(rd_data),
        .o_rd_valid(rd_valid), .o_idle(idle), .link(link));
    sdrt_dev u_sdrt_dev (.i_clk(i_clk), .i_sys_rst(rst), .link(link), .o_bank_open(bank_open),
        .o_mode0(mode0), .o_mode1(mode1));
    sdrt_link_monitor u_mon (.i_clk(i_clk), .i_sys_rst(rst), .cmd_valid(link.cmd_valid),
        .cmd_op(link.cmd_op), .cmd_bank(link.cmd_bank), .cmd_addr(link.cmd_addr),
        .rdq_valid(link.rdq_valid), .rdq_inv(link.rdq_inv));
    // Prints the counts and the verdict, then stops.
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Compares a state word or a count.
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Compares a whole burst, beat 0 in the low byte.
    task automatic chk_data(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Cuts a hang short.
    task automatic hang();
        mismatches++;
        final_report();
    endtask
    // Presents one request and holds it until taken.
    task automatic send(input sdrt_op_e o, input logic [1:0] b, input sdrt_addr_t a,
                        input logic l, input logic [7:0] d);
        int n;
        req_valid <= 1'b1;
        req_op <= o;
        req_bank <= b;
        req_addr <= a;
        req_long <= l;
        req_wdata <= d;
        @(posedge i_clk);
        for (n = 0; n < 200 && req_ready !== 1'b1; n++) @(posedge i_clk);
        if (n == 200) hang();
        req_valid <= 1'b0;
    endtask
    // Waits until the controller is quiet again.
    task automatic wait_idle();
        int n;
        @(posedge i_clk);
        for (n = 0; n < 300 && idle !== 1'b1; n++) @(posedge i_clk);
        if (n == 300) hang();
    endtask
    task automatic go(input sdrt_op_e o, input logic [1:0] b, input sdrt_addr_t a,
                      input logic [7:0] d);
        send(o, b, a, 1'b0, d);
        wait_idle();
    endtask
    // Reads a burst and checks its beat count and data.
    task automatic rd(input sdrt_addr_t a, input logic l, input int n_exp, input logic [63:0] exp);
        logic [63:0] got;
        int n;
        int t;
        got = '0;
        n = 0;
        send(OP_RD, 2'h0, a, l, 8'h00);
        for (t = 0; t < 300; t++) begin
            @(posedge i_clk);
            if (rd_valid === 1'b1) begin
                if (n < 8) got[8*n +: 8] = rd_data;
                n++;
            end else if (n > 0 && idle === 1'b1) begin
                break;
            end
        end
        if (t == 300) hang();
        chk(13'(n), 13'(n_exp));
        chk_data(got, exp);
    endtask
    // Main sequence.
    initial begin
        repeat (4) @(posedge i_clk);
        rst <= 1'b0;
        @(posedge i_clk);
        chk(mode0, 13'h0000);
        chk({12'h000, req_ready & idle}, 13'h0001);
        go(OP_ACT, 2'h0, 13'h0000, 8'h00);
        go(OP_WR, 2'h0, 13'h0000, 8'h10);
        rd(13'h0000, 1'b0, 8, 64'h1716_1514_1312_1110);
        $display("test fixed eight done");
        go(OP_MRS, MR_SEL_ZERO, 13'h0002, 8'h00);
        chk(mode0, 13'h0002);
        go(OP_WR, 2'h0, 13'h0000, 8'h40);
        rd(13'h0000, 1'b0, 4, 64'h0000_0000_4342_4140);
        $display("test fixed chop done");
        go(OP_MRS, MR_SEL_ZERO, 13'h0001, 8'h00);
        rd(13'h1000, 1'b1, 8, 64'h1716_1514_4342_4140);
        rd(13'h0000, 1'b0, 4, 64'h0000_0000_4342_4140);
        $display("test per command done");
        go(OP_MRS, MR_SEL_ZERO, 13'h0000, 8'h00);
        go(OP_MRS, MR_SEL_ONE, 13'h0001, 8'h00);
        rd(13'h0000, 1'b0, 8, 64'h1716_1514_4342_4140);
        go(OP_MRS, MR_SEL_ONE, 13'h0002, 8'h00);
        rd(13'h0000, 1'b0, 8, 64'h1716_1514_4342_4140);
        go(OP_MRS, MR_SEL_ONE, 13'h0000, 8'h00);
        go(OP_MRS, MR_SEL_ZERO, 13'h0010, 8'h00);
        rd(13'h0000, 1'b0, 8, 64'h1716_1514_4342_4140);
        $display("test latency adders done");
        go(OP_MRS, MR_SEL_ONE, 13'h0004, 8'h00);
        chk(mode1, 13'h000c);
        go(OP_MRS, MR_SEL_ZERO, 13'h0200, 8'h00);
        send(OP_RD, 2'h0, 13'h0000, 1'b0, 8'h00);
        @(posedge i_clk);
        send(OP_PRE, 2'h0, 13'h0000, 1'b0, 8'h00);
        wait_idle();
        @(posedge i_clk);
        chk({9'h000, bank_open}, 13'h0000);
        go(OP_ACT, 2'h0, 13'h0000, 8'h00);
        @(posedge i_clk);
        chk({9'h000, bank_open}, 13'h0001);
        rd(13'h0400, 1'b0, 8, 64'h1716_1514_4342_4140);
        chk({9'h000, bank_open}, 13'h0000);
        $display("test precharge done");
        final_report();
    end
endmodule
`default_nettype wire
